// ==== core/quality_status_defs.svh ====
`ifndef QUALITY_STATUS_DEFS_SVH
`define QUALITY_STATUS_DEFS_SVH

// Register group selectors carried with each command
`define QS_SEL_SUMMARY     2'h0
`define QS_SEL_VOLTAGE     2'h1
`define QS_SEL_TEMPERATURE 2'h2
`define QS_NUM_GROUPS      3

// Field positions in the summary and trip registers
`define QS_SUM_VOLTAGE_BIT 0
`define QS_SUM_TEMP_BIT    4
`define QS_OVER_V_BIT      0
`define QS_UNDER_V_BIT     1
`define QS_OVER_T_BIT      0
`define QS_SUM_USED_MASK   16'h0011

// Reset and preset values of the masks
`define QS_SUM_EN_PRESET   16'h0000
`define QS_SUM_RISE_PRESET 16'hFFFF
`define QS_SUM_FALL_PRESET 16'h0000
`define QS_SUB_EN_PRESET   16'hFFFF
`define QS_SUB_RISE_PRESET 16'hFFFF
`define QS_SUB_FALL_PRESET 16'hFFFF

// Error queue
`define QS_QUEUE_DEPTH     3'h4
`define QS_QUEUE_LAST      2'h3
`define QS_OVERFLOW_CODE   16'hFEA2
`define QS_NO_ERROR_CODE   16'h0000
`define QS_DESC_MAX_LEN    255

`endif

// ==== core/quality_status_pkg.sv ====
package quality_status_pkg;

  // Decoded host status commands
  typedef enum logic [3:0] {
    OP_READ_EVENT,
    OP_READ_COND,
    OP_WRITE_ENABLE,
    OP_READ_ENABLE,
    OP_WRITE_RISE,
    OP_READ_RISE,
    OP_WRITE_FALL,
    OP_READ_FALL,
    OP_ERR_NEXT,
    OP_ERR_CODE,
    OP_ERR_COUNT,
    OP_CLEAR,
    OP_PRESET
  } cmd_op_e;

  typedef logic [15:0] word_t;

endpackage

// ==== core/quality_status_error_queue.sv ====
`timescale 1ns/1ns
`include "quality_status_defs.svh"
// Summary of operation
// - Quality summary register is sixteen bits wide
// - Summary bit ORs the enabled events of its feeding register
// - Summary bit 0 reports voltage trips
// - Summary bit 4 reports temperature trip
// - Other summary bits never asserted
// - Voltage bit 0 over, bit 1 under
// - Temperature bit 0 flags overheating
// - Events, conditions readable; masks writable, readable
// - Entry holds signed 16-bit event number
// - Code zero means no error
// - Description text at most 255 characters
// - Queue is strictly first in first out
// - Queue holds at most four entries
// - Overflow keeps oldest, last becomes -350
// - Non-empty queue raises status byte bit
// - Full read pops oldest; empty returns zero
// - Code-only read pops oldest, code only
// - Clear empties events and the queue
// - Preset sets summary masks 0,1,0
// - Device reset leaves these registers alone
module quality_status_error_queue (
  input  wire logic                       clock_i,
  input  wire logic                       srst_i,
  input  wire logic                       over_voltage_flag_i,
  input  wire logic                       under_voltage_flag_i,
  input  wire logic                       over_temp_flag_i,
  input  wire logic                       err_push_i,
  input  wire quality_status_pkg::word_t  err_code_i,
  input  wire logic                       cmd_valid_i,
  input  wire quality_status_pkg::cmd_op_e cmd_op_i,
  input  wire logic [1:0]                 cmd_sel_i,
  input  wire quality_status_pkg::word_t  cmd_data_i,
  output logic                            rsp_valid_o,
  output quality_status_pkg::word_t       rsp_data_o,
  output logic                            rsp_desc_o,
  output logic                            err_queue_flag_o,
  output logic                            quality_summary_o
);

  // Trip flags come from analogue comparators on their own timing
  logic [2:0]  sync1_q;
  logic [2:0]  sync2_q;
  logic [2:0]  sync3_q;
  logic [2:0]  flags_q;
  wire  [2:0]  flags_settled = ~(sync2_q ^ sync3_q);

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      sync1_q <= 3'h0;
      sync2_q <= 3'h0;
      sync3_q <= 3'h0;
      flags_q <= 3'h0;
    end else begin
      sync1_q <= {over_temp_flag_i, under_voltage_flag_i,
                  over_voltage_flag_i};
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
      // A flag only moves once two stages agree, filtering glitches
      flags_q <= (sync3_q & flags_settled) | (flags_q & ~flags_settled);
    end
  end

  // Command decode
  wire is_rd_event = cmd_valid_i &&
                     (cmd_op_i == quality_status_pkg::OP_READ_EVENT);
  wire is_wr_en    = cmd_valid_i &&
                     (cmd_op_i == quality_status_pkg::OP_WRITE_ENABLE);
  wire is_wr_rise  = cmd_valid_i &&
                     (cmd_op_i == quality_status_pkg::OP_WRITE_RISE);
  wire is_wr_fall  = cmd_valid_i &&
                     (cmd_op_i == quality_status_pkg::OP_WRITE_FALL);
  wire is_clear    = cmd_valid_i &&
                     (cmd_op_i == quality_status_pkg::OP_CLEAR);
  wire is_preset   = cmd_valid_i &&
                     (cmd_op_i == quality_status_pkg::OP_PRESET);
  wire is_pop_full = cmd_valid_i &&
                     (cmd_op_i == quality_status_pkg::OP_ERR_NEXT);
  wire is_pop_code = cmd_valid_i &&
                     (cmd_op_i == quality_status_pkg::OP_ERR_CODE);
  wire is_write    = is_wr_en || is_wr_rise || is_wr_fall ||
                     is_clear || is_preset;
  wire sel_ok      = (cmd_sel_i <= `QS_SEL_TEMPERATURE);

  // Status groups: 0 summary, 1 voltage trips, 2 temperature trip
  logic [2:0][15:0] cond_w;
  logic [2:0][15:0] prev_q;
  logic [2:0][15:0] event_q;
  logic [2:0][15:0] en_q;
  logic [2:0][15:0] rise_q;
  logic [2:0][15:0] fall_q;
  logic [2:0]       group_sum;

  // Group condition inputs; unlisted bits are held at zero
  assign cond_w[1] = {14'h0000, flags_q[1], flags_q[0]};
  assign cond_w[2] = {15'h0000, flags_q[2]};
  assign cond_w[0] = {11'h000, group_sum[2],
                      3'h0, group_sum[1]};

  genvar g;
  generate
    for (g = 0; g < `QS_NUM_GROUPS; g++) begin : grp
      localparam logic [15:0] EN_PRE =
        (g == 0) ? `QS_SUM_EN_PRESET : `QS_SUB_EN_PRESET;
      localparam logic [15:0] RISE_PRE =
        (g == 0) ? `QS_SUM_RISE_PRESET : `QS_SUB_RISE_PRESET;
      localparam logic [15:0] FALL_PRE =
        (g == 0) ? `QS_SUM_FALL_PRESET : `QS_SUB_FALL_PRESET;
      wire hit = sel_ok && (cmd_sel_i == 2'(g));
      // Edge filters pick which transitions become events
      wire [15:0] ev_set = (rise_q[g] & cond_w[g] & ~prev_q[g]) |
                           (fall_q[g] & ~cond_w[g] & prev_q[g]);
      wire        ev_clr = is_clear || (is_rd_event && hit);
      // A new edge in the clearing cycle survives the clear
      wire [15:0] ev_d = (ev_clr ? 16'h0000 : event_q[g]) | ev_set;

      // Only enabled events reach the level above
      assign group_sum[g] = |(event_q[g] & en_q[g]);

      // No other reset reaches these; power-on clears to preset values
      always_ff @(posedge clock_i) begin
        if (srst_i) begin
          prev_q[g]  <= 16'h0000;
          event_q[g] <= 16'h0000;
          en_q[g]    <= EN_PRE;
          rise_q[g]  <= RISE_PRE;
          fall_q[g]  <= FALL_PRE;
        end else begin
          prev_q[g]  <= cond_w[g];
          event_q[g] <= ev_d;
          if (is_preset) begin
            en_q[g]   <= EN_PRE;
            rise_q[g] <= RISE_PRE;
            fall_q[g] <= FALL_PRE;
          end else begin
            if (is_wr_en && hit) begin
              en_q[g] <= cmd_data_i;
            end
            if (is_wr_rise && hit) begin
              rise_q[g] <= cmd_data_i;
            end
            if (is_wr_fall && hit) begin
              fall_q[g] <= cmd_data_i;
            end
          end
        end
      end
    end
  endgenerate

  // Error queue: ring of four words, head points at the oldest entry
  logic [3:0][15:0] q_mem;
  logic [1:0]       head_q;
  logic [2:0]       count_q;

  wire        pop_req  = is_pop_full || is_pop_code;
  wire        pop_do   = pop_req && (count_q != 3'h0);
  wire [2:0]  base_cnt = is_clear ? 3'h0 : count_q;
  // A pop in the same cycle frees a slot, so no overflow then
  wire        full_eff = (base_cnt == `QS_QUEUE_DEPTH) && !pop_do;
  wire        push_acc = err_push_i && !full_eff;
  wire        push_ovf = err_push_i && full_eff;
  wire [1:0]  tail     = head_q + base_cnt[1:0];
  wire [1:0]  last_idx = head_q + `QS_QUEUE_LAST;
  wire [1:0]  wr_idx   = push_ovf ? last_idx : tail;
  // Newest event is dropped; the last slot records the overflow
  wire [15:0] wr_word  = push_ovf ? `QS_OVERFLOW_CODE : err_code_i;
  wire [2:0]  count_d  = base_cnt + {2'b00, push_acc} - {2'b00, pop_do};
  wire [1:0]  head_d   = head_q + {1'b0, pop_do};
  wire [15:0] head_word = (count_q != 3'h0) ? q_mem[head_q]
                                            : `QS_NO_ERROR_CODE;

  generate
    for (g = 0; g < 4; g++) begin : slot
      // Each slot keeps a raw signed code; text is looked up by code
      always_ff @(posedge clock_i) begin
        if (srst_i) begin
          q_mem[g] <= `QS_NO_ERROR_CODE;
        end else if (err_push_i && (wr_idx == 2'(g))) begin
          q_mem[g] <= wr_word;
        end
      end
    end
  endgenerate

  // Queue pointers; a push during a clear survives it
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      head_q  <= 2'h0;
      count_q <= 3'h0;
    end else begin
      head_q  <= head_d;
      count_q <= count_d;
    end
  end

  // Query response selection
  logic [15:0] rsp_d;
  wire  [1:0]  gi = sel_ok ? cmd_sel_i : 2'h0;
  wire  [15:0] sel_mask = sel_ok ? 16'hFFFF : 16'h0000;

  always_comb begin
    rsp_d = 16'h0000;
    unique case (cmd_op_i)
      quality_status_pkg::OP_READ_EVENT: rsp_d = event_q[gi] & sel_mask;
      quality_status_pkg::OP_READ_COND:  rsp_d = cond_w[gi] & sel_mask;
      quality_status_pkg::OP_READ_ENABLE: rsp_d = en_q[gi] & sel_mask;
      quality_status_pkg::OP_READ_RISE:  rsp_d = rise_q[gi] & sel_mask;
      quality_status_pkg::OP_READ_FALL:  rsp_d = fall_q[gi] & sel_mask;
      quality_status_pkg::OP_ERR_NEXT:   rsp_d = head_word;
      quality_status_pkg::OP_ERR_CODE:   rsp_d = head_word;
      quality_status_pkg::OP_ERR_COUNT:  rsp_d = {13'h0000, count_q};
      default:                           rsp_d = 16'h0000;
    endcase
  end

  // Registered answer one cycle after the command
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      rsp_valid_o       <= 1'b0;
      rsp_data_o        <= 16'h0000;
      rsp_desc_o        <= 1'b0;
      err_queue_flag_o  <= 1'b0;
      quality_summary_o <= 1'b0;
    end else begin
      rsp_valid_o       <= cmd_valid_i && !is_write;
      // Answer words stand until the next command replaces them
      if (cmd_valid_i) begin
        rsp_data_o <= rsp_d;
        rsp_desc_o <= is_pop_full;
      end
      err_queue_flag_o  <= (count_d != 3'h0);
      quality_summary_o <= group_sum[0];
    end
  end

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (srst_i);
  // Checks on internal state and outputs; all quiet while reset is held

  sum_unused_zero_a: assert property (
    (cond_w[0] & ~`QS_SUM_USED_MASK) == 16'h0000)
    else $error("unused summary bit asserted");
  volt_summary_a: assert property (
    cond_w[0][`QS_SUM_VOLTAGE_BIT] == |(event_q[1] & en_q[1]))
    else $error("voltage summary mismatch");
  temp_summary_a: assert property (
    cond_w[0][`QS_SUM_TEMP_BIT] == |(event_q[2] & en_q[2]))
    else $error("temperature summary mismatch");
  rise_latch_a: assert property (
    (rise_q[1][0] && cond_w[1][0] && !prev_q[1][0]) |=> event_q[1][0])
    else $error("rising edge not latched");
  event_clear_a: assert property (
    (is_rd_event && cmd_sel_i == `QS_SEL_TEMPERATURE &&
     !(cond_w[2][0] ^ prev_q[2][0])) |=> event_q[2] == 16'h0000)
    else $error("event read did not clear");
  queue_bound_a: assert property (
    count_q <= `QS_QUEUE_DEPTH)
    else $error("queue holds more than four");
  overflow_code_a: assert property (
    push_ovf |=> (q_mem[$past(last_idx)] == `QS_OVERFLOW_CODE) &&
                 count_q == `QS_QUEUE_DEPTH)
    else $error("overflow entry not written");
  queue_flag_a: assert property (
    ##1 err_queue_flag_o == (count_q != 3'h0))
    else $error("queue flag wrong");
  empty_read_a: assert property (
    (pop_req && count_q == 3'h0) |=> rsp_valid_o && rsp_data_o == 16'h0000)
    else $error("empty read not zero");
  pop_order_a: assert property (
    (pop_do && !err_push_i) |=> count_q == $past(count_q) - 3'h1 &&
      rsp_data_o == q_mem[$past(head_q)])
    else $error("pop not oldest first");
  code_only_a: assert property (
    is_pop_code |=> rsp_valid_o && !rsp_desc_o)
    else $error("code read carried text");
  clear_all_a: assert property (
    (is_clear && !err_push_i) |=> count_q == 3'h0 && !err_queue_flag_o)
    else $error("clear left queue entries");
  preset_masks_a: assert property (
    is_preset |=> en_q[0] == `QS_SUM_EN_PRESET &&
      rise_q[0] == `QS_SUM_RISE_PRESET && fall_q[0] == `QS_SUM_FALL_PRESET)
    else $error("preset values wrong");
  fall_latch_a: assert property (
    (fall_q[1][1] && !cond_w[1][1] && prev_q[1][1]) |=> event_q[1][1])
    else $error("falling edge not latched");
  summary_out_a: assert property (
    ##1 quality_summary_o == $past(group_sum[0]))
    else $error("summary output wrong");
  write_silent_a: assert property (
    is_write |=> !rsp_valid_o)
    else $error("write gave an answer");
  fall_write_a: assert property (
    (is_wr_fall && cmd_sel_i == `QS_SEL_VOLTAGE) |=>
      fall_q[1] == $past(cmd_data_i))
    else $error("fall filter write lost");
  cond_keep_a: assert property (
    (cmd_valid_i && cmd_op_i == quality_status_pkg::OP_READ_COND) |=>
      (event_q[1] & $past(event_q[1])) == $past(event_q[1]))
    else $error("condition read cleared events");

endmodule

// ==== tb/qs_host.sv ====
`timescale 1ns/1ns
// Host side of the status port: one decoded command per call
module qs_host (
  input  wire logic                      clock_i,
  output logic                           cmd_valid_o,
  output quality_status_pkg::cmd_op_e    cmd_op_o,
  output logic [1:0]                     cmd_sel_o,
  output quality_status_pkg::word_t      cmd_data_o,
  input  wire logic                      rsp_valid_i,
  input  wire quality_status_pkg::word_t rsp_data_i,
  input  wire logic                      rsp_desc_i
);
  // Idle values from time zero so nothing is taken before reset ends
  initial begin
    cmd_valid_o = 1'h0;
    cmd_op_o    = quality_status_pkg::OP_READ_COND;
    cmd_sel_o   = 2'h0;
    cmd_data_o  = 16'h0000;
  end

  // Request held until the taking edge; the answer's valid flag stands one cycle only,
  // so it is sampled mid-cycle right after that edge
  task automatic xfer(input logic [3:0] op, input logic [1:0] sel,
                      input quality_status_pkg::word_t wd,
                      output quality_status_pkg::word_t rd,
                      output logic ds, output logic vld);
    @(posedge clock_i);
    cmd_valid_o <= 1'h1;
    cmd_op_o    <= quality_status_pkg::cmd_op_e'(op);
    cmd_sel_o   <= sel;
    cmd_data_o  <= wd;
    @(posedge clock_i);
    cmd_valid_o <= 1'h0;
    @(negedge clock_i);
    vld = rsp_valid_i;
    rd  = rsp_data_i;
    ds  = rsp_desc_i;
  endtask
endmodule

// ==== tb/tb_quality_status_error_queue.sv ====
`timescale 1ns/1ns
`include "quality_status_defs.svh"
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin \
  fail_count++; $display("[FAIL] %0t got %h exp %h", $time, g, e); end end
module tb_quality_status_error_queue;
  logic                        clock, srst, ov, uv, ot, push;
  logic                        cmd_valid, rsp_valid, rsp_desc, ds, vld;
  logic                        q_flag, q_sum;
  logic [1:0]                  cmd_sel;
  quality_status_pkg::cmd_op_e cmd_op;
  quality_status_pkg::word_t   code, cmd_data, rsp_data, rd;
  int                          fail_count, checks_done, cycles;

  quality_status_error_queue u_quality_status_error_queue (
    .clock_i(clock), .srst_i(srst), .over_voltage_flag_i(ov),
    .under_voltage_flag_i(uv), .over_temp_flag_i(ot),
    .err_push_i(push), .err_code_i(code), .cmd_valid_i(cmd_valid),
    .cmd_op_i(cmd_op), .cmd_sel_i(cmd_sel), .cmd_data_i(cmd_data),
    .rsp_valid_o(rsp_valid), .rsp_data_o(rsp_data), .rsp_desc_o(rsp_desc),
    .err_queue_flag_o(q_flag), .quality_summary_o(q_sum));
  qs_host u_qs_host (
    .clock_i(clock), .cmd_valid_o(cmd_valid), .cmd_op_o(cmd_op),
    .cmd_sel_o(cmd_sel), .cmd_data_o(cmd_data), .rsp_valid_i(rsp_valid),
    .rsp_data_i(rsp_data), .rsp_desc_i(rsp_desc));

  always #25 clock = ~clock;

  // Hang guard: a run of under two hundred cycles never gets near this
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      fail_count++;
      print_verdict();
    end
  end

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // Ops in package enum order: 0 event, 1 cond, 2/3 enable w/r,
  // 4/5 rise w/r, 6/7 fall w/r, 8 next, 9 code, A count, B clear, C preset.
  // Writes, clear and preset must give no answer at all.
  task automatic q(input logic [3:0] op, input logic [1:0] s,
                   input quality_status_pkg::word_t e);
    logic ans;
    ans = (op < 4'h8) ? (op == 4'h0 || op[0]) : (op <= 4'hA);
    u_qs_host.xfer(op, s, e, rd, ds, vld);
    `CHK(vld, ans)
    if (ans) `CHK(rd, e)
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
  endtask

  task automatic push_code(input quality_status_pkg::word_t c);
    @(posedge clock);
    push <= 1'h1;
    code <= c;
    @(posedge clock);
    push <= 1'h0;
  endtask

  task automatic t_reset();
    q(4'h3, 2'h0, `QS_SUM_EN_PRESET);
    q(4'h5, 2'h0, `QS_SUM_RISE_PRESET);
    q(4'h7, 2'h0, `QS_SUM_FALL_PRESET);
    for (int s = 1; s < 3; s++) begin
      q(4'h3, s[1:0], `QS_SUB_EN_PRESET);
      q(4'h5, s[1:0], `QS_SUB_RISE_PRESET);
      q(4'h7, s[1:0], `QS_SUB_FALL_PRESET);
    end
  endtask

  // Flags pass a synchroniser, so each change is given ten cycles
  task automatic t_trips();
    @(posedge clock);
    ov <= 1'h1;
    cyc(10);
    q(4'h1, 2'h1, 16'h0001);
    q(4'h1, 2'h0, 16'h0001);
    `CHK(q_sum, 1'h0)
    q(4'h2, 2'h0, 16'h0001);
    cyc(3);
    `CHK(q_sum, 1'h1)
    q(4'h0, 2'h1, 16'h0001);
    q(4'h0, 2'h1, 16'h0000);
    q(4'h1, 2'h1, 16'h0001);
    q(4'h0, 2'h0, 16'h0001);
    cyc(3);
    `CHK(q_sum, 1'h0)
    @(posedge clock);
    uv <= 1'h1;
    ot <= 1'h1;
    cyc(10);
    q(4'h1, 2'h1, 16'h0003);
    q(4'h1, 2'h2, 16'h0001);
    q(4'h1, 2'h0, 16'h0011);
    @(posedge clock);
    ov <= 1'h0;
    cyc(10);
    q(4'h0, 2'h1, 16'h0003);
    @(posedge clock);
    uv <= 1'h0;
    ot <= 1'h0;
    cyc(10);
  endtask

  // Voltage fall filter written and read back; unmapped group reads zero and ignores writes
  task automatic t_masks();
    q(4'h6, 2'h1, 16'h00A5);
    q(4'h7, 2'h1, 16'h00A5);
    q(4'h2, 2'h3, 16'h1234);
    q(4'h3, 2'h3, 16'h0000);
    q(4'h1, 2'h3, 16'h0000);
  endtask

  task automatic t_preset();
    push_code(16'h0007);
    q(4'h4, 2'h0, 16'h0000);
    q(4'hC, 2'h0, 16'h0000);
    q(4'h3, 2'h0, `QS_SUM_EN_PRESET);
    q(4'h5, 2'h0, `QS_SUM_RISE_PRESET);
    q(4'h7, 2'h1, `QS_SUB_FALL_PRESET);
    q(4'hA, 2'h0, 16'h0001);
  endtask

  task automatic t_clear();
    push_code(16'h0009);
    @(posedge clock);
    ot <= 1'h1;
    cyc(10);
    q(4'hB, 2'h0, 16'h0000);
    cyc(2);
    `CHK(q_flag, 1'h0)
    q(4'hA, 2'h0, 16'h0000);
    q(4'h0, 2'h2, 16'h0000);
    @(posedge clock);
    ot <= 1'h0;
  endtask

  // Five pushes into four slots: the fifth is lost, the last slot overflows
  task automatic t_queue();
    quality_status_pkg::word_t c[5];
    c = '{16'hFF9A, 16'h0001, 16'h7FFF, 16'h8000, 16'h0005};
    foreach (c[i]) push_code(c[i]);
    cyc(2);
    `CHK(q_flag, 1'h1)
    q(4'hA, 2'h0, 16'h0004);
    u_qs_host.xfer(4'h8, 2'h0, 16'h0000, rd, ds, vld);
    `CHK({vld, ds, rd}, {2'h3, 16'hFF9A})
    u_qs_host.xfer(4'h9, 2'h0, 16'h0000, rd, ds, vld);
    `CHK({vld, ds, rd}, {2'h2, 16'h0001})
    q(4'h8, 2'h0, 16'h7FFF);
    `CHK(q_flag, 1'h1)
    q(4'h8, 2'h0, `QS_OVERFLOW_CODE);
    `CHK(q_flag, 1'h0)
    q(4'h8, 2'h0, `QS_NO_ERROR_CODE);
  endtask

  initial begin
    fail_count = 0;
    checks_done = 0;
    cycles = 0;
    clock = 1'h0;
    srst = 1'h1;
    ov = 1'h0;
    uv = 1'h0;
    ot = 1'h0;
    push = 1'h0;
    code = 16'h0000;
    repeat (20) @(posedge clock);
    srst <= 1'h0;
    t_reset();
    t_trips();
    t_masks();
    t_preset();
    t_clear();
    t_queue();
    print_verdict();
  end
endmodule
